// ---- design/wscte_bchain.sv ----
// Boundary cell chain: input cells first, then output cells.
// Assumes capture, shift and update strobes are already qualified by selection.
module wscte_bchain
    import wscte_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic capture_en,
    input wire logic shift_en,
    input wire logic update_en,
    input wire logic serial_in,
    input wire logic [WSCTE_CORE_OUT_W-1:0] core_resp,
    output logic [WSCTE_CORE_IN_W-1:0] stim,
    output logic serial_out
);

    typedef struct packed {
        logic [WSCTE_CHAIN_W-1:0] shift;
        logic [WSCTE_CORE_IN_W-1:0] upd;
    } wscte_bchain_st_t;

    wscte_bchain_st_t st_reg;
    wscte_bchain_st_t st_next;
    logic [WSCTE_CHAIN_W-1:0] cap_val;
    logic [WSCTE_CHAIN_W-1:0] shift_val;

    genvar i;
    generate
        for (i = 0; i < WSCTE_CHAIN_W; i = i + 1) begin : g_cell
            if (i < WSCTE_CORE_IN_W) begin : g_in
                // input cells recapture their own applied value
                assign cap_val[i] = st_reg.upd[i];
            end else begin : g_out
                // output cells capture the core response
                assign cap_val[i] = core_resp[i-WSCTE_CORE_IN_W];
            end
            if (i == 0) begin : g_head
                assign shift_val[i] = serial_in;
            end else begin : g_body
                assign shift_val[i] = st_reg.shift[i-1];
            end
        end
    endgenerate

    always_comb begin
        st_next = st_reg;
        if (capture_en) begin
            st_next.shift = cap_val;
        end else if (shift_en) begin
            st_next.shift = shift_val;
        end
        if (update_en) begin
            st_next.upd = st_reg.shift[WSCTE_CORE_IN_W-1:0];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_reg.shift <= WSCTE_CHAIN_RESET;
            st_reg.upd <= WSCTE_CORE_IN_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign stim = st_reg.upd;
    assign serial_out = st_reg.shift[WSCTE_CHAIN_W-1];

endmodule

// ---- design/wscte_pkg.sv ----
// Shared constants for the serial core-test wrapper paths.
// Assumes a single core with a fixed number of boundary-cell terminals.
package wscte_pkg;

    // Core terminal counts
    localparam int unsigned WSCTE_CORE_IN_W = 4;
    localparam int unsigned WSCTE_CORE_OUT_W = 4;
    localparam int unsigned WSCTE_CHAIN_W = WSCTE_CORE_IN_W + WSCTE_CORE_OUT_W;

    // Instruction register
    localparam int unsigned WSCTE_IR_W = 3;
    localparam logic [2:0] WSCTE_OP_BYPASS = 3'h0;
    localparam logic [2:0] WSCTE_OP_RING = 3'h1;
    localparam logic [2:0] WSCTE_OP_SCAN = 3'h2;
    localparam logic [2:0] WSCTE_IR_RESET = 3'h0;

    // Safe level on functional outputs during core test
    localparam logic [3:0] WSCTE_SAFE_OUT = 4'h0;

    // Reset values of the core-facing registers
    localparam logic [3:0] WSCTE_CORE_IN_RESET = 4'h0;
    localparam logic [3:0] WSCTE_FOUT_RESET = 4'h0;
    localparam logic [7:0] WSCTE_CHAIN_RESET = 8'h00;

    // Active serial path of the wrapper
    typedef enum logic [1:0] {
        WSCTE_PATH_IR,
        WSCTE_PATH_BYPASS,
        WSCTE_PATH_RING,
        WSCTE_PATH_SCAN
    } wscte_path_t;

endpackage

// ---- design/wscte_sync.sv ----
// Two-flop level synchroniser, one flop pair per bit.
// Assumes each input bit is a level from another clock domain or a pin.
module wscte_sync
    import wscte_pkg::*;
#(
    parameter int unsigned W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } wscte_sync_st_t;

    wscte_sync_st_t st_reg;
    wscte_sync_st_t st_next;

    always_comb begin
        st_next = st_reg;
        if (ce) begin
            st_next.s1 = d;
            st_next.s2 = st_reg.s1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign q = st_reg.s2;

endmodule

// ---- design/wscte_top.sv ----
// Serial wrapper with ring and scan core-test paths around one core.
// Assumes the wrapper control pins are timed to wrapper_test_clock and the
// core runs on clock; the core's scan cells shift on wrapper_test_clock.
module wscte_top
    import wscte_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    input wire logic wrapper_test_clock,
    input wire logic wrapper_reset_n,
    input wire logic select_instr,
    input wire logic capture_en,
    input wire logic shift_en,
    input wire logic update_en,
    input wire logic serial_test_in,
    output logic serial_test_out,
    output logic internal_chain_mode,
    output logic internal_chain_in,
    input wire logic internal_chain_tail,
    input wire logic [WSCTE_CORE_IN_W-1:0] func_in,
    output logic [WSCTE_CORE_IN_W-1:0] core_in,
    input wire logic [WSCTE_CORE_OUT_W-1:0] core_out,
    output logic [WSCTE_CORE_OUT_W-1:0] functional_output_terminal,
    output logic core_step,
    output logic core_test_mode
);

    // Wrapper clock domain state
    typedef struct packed {
        logic [WSCTE_IR_W-1:0] ir_shift;
        logic ring;
        logic scan;
        logic test;
        logic bypass;
        logic sout;
        logic step_tgl;
    } wscte_wr_st_t;

    // Core clock domain state
    typedef struct packed {
        logic tgl_seen;
        logic test;
        logic step;
        logic [WSCTE_CORE_IN_W-1:0] stim;
        logic [WSCTE_CORE_IN_W-1:0] cin;
        logic [WSCTE_CORE_OUT_W-1:0] fout;
    } wscte_core_st_t;

    wscte_wr_st_t wr_reg;
    wscte_wr_st_t wr_next;
    wscte_core_st_t cr_reg;
    wscte_core_st_t cr_next;

    logic wr_rst;
    wscte_path_t path;
    logic dr_sel_ring_scan;
    logic bc_capture;
    logic bc_shift;
    logic bc_update;
    logic bc_sout;
    logic [WSCTE_CORE_IN_W-1:0] bc_stim;
    logic [WSCTE_CORE_OUT_W-1:0] core_out_wr;
    logic [1:0] wr_to_core;
    logic [WSCTE_CORE_IN_W-1:0] func_in_sync;
    logic path_out;

    // wrapper reset clears the instruction and the chain
    // Either reset clears the wrapper clock domain at once; its release is not timed to
    // wrapper_test_clock, so the controller keeps the strobes low around it
    assign wr_rst = rst | ~wrapper_reset_n;

    // wrapper test logic below, up to the core clock domain crossing, runs on wrapper_test_clock
    always_comb begin
        if (select_instr) begin
            path = WSCTE_PATH_IR;
        end else if (wr_reg.ring) begin
            path = WSCTE_PATH_RING;
        end else if (wr_reg.scan) begin
            path = WSCTE_PATH_SCAN;
        end else begin
            path = WSCTE_PATH_BYPASS;
        end
    end

    // control pins operate only the selected register
    assign dr_sel_ring_scan = (path == WSCTE_PATH_RING) || (path == WSCTE_PATH_SCAN);
    assign bc_capture = dr_sel_ring_scan & capture_en;
    assign bc_shift = dr_sel_ring_scan & shift_en;
    assign bc_update = dr_sel_ring_scan & update_en;

    // Input cells 0..3 sit nearest serial_test_in, output cells 4..7 last
    wscte_bchain u_bchain (
        .clk(wrapper_test_clock),
        .rst(wr_rst),
        .capture_en(bc_capture),
        .shift_en(bc_shift),
        .update_en(bc_update),
        .serial_in(serial_test_in),
        .core_resp(core_out_wr),
        .stim(bc_stim),
        .serial_out(bc_sout)
    );

    // Core response into the wrapper clock domain
    wscte_sync #(
        .W(WSCTE_CORE_OUT_W)
    ) u_sync_resp (
        .clk(wrapper_test_clock),
        .rst(wr_rst),
        .ce(1'b1),
        .d(core_out),
        .q(core_out_wr)
    );

    // Serial output selection
    always_comb begin
        case (path)
            WSCTE_PATH_IR: begin
                path_out = wr_reg.ir_shift[0];
            end
            // ring puts only the boundary chain on the serial path
            WSCTE_PATH_RING: begin
                path_out = bc_sout;
            end
            // scan path returns through the internal chain tail
            WSCTE_PATH_SCAN: begin
                path_out = internal_chain_tail;
            end
            WSCTE_PATH_BYPASS: begin
                path_out = wr_reg.bypass;
            end
            default: begin
                path_out = wr_reg.bypass;
            end
        endcase
    end

    always_comb begin
        wr_next = wr_reg;
        // instructions and data share the serial pins
        wr_next.sout = path_out;
        if (path == WSCTE_PATH_IR) begin
            if (capture_en) begin
                wr_next.ir_shift = {1'b0, wr_reg.scan, wr_reg.ring};
            end else if (shift_en) begin
                wr_next.ir_shift = {serial_test_in, wr_reg.ir_shift[WSCTE_IR_W-1:1]};
            end
            // mode changes only at instruction update
            // one decode each for ring and scan, all other codes fall to bypass
            if (update_en) begin
                wr_next.ring = 1'b0;
                wr_next.scan = 1'b0;
                case (wr_reg.ir_shift)
                    WSCTE_OP_RING: begin
                        wr_next.ring = 1'b1;
                    end
                    WSCTE_OP_SCAN: begin
                        wr_next.scan = 1'b1;
                    end
                    default: begin
                        // Both paths off: bypass is selected
                    end
                endcase
                wr_next.test = wr_next.ring | wr_next.scan;
            end
        end
        // Single-bit bypass, also the path for unknown opcodes
        if (path == WSCTE_PATH_BYPASS) begin
            if (capture_en) begin
                wr_next.bypass = 1'b0;
            end else if (shift_en) begin
                wr_next.bypass = serial_test_in;
            end
        end
        // each completed fill requests one core step
        if (bc_update) begin
            wr_next.step_tgl = ~wr_reg.step_tgl;
        end
    end

    always_ff @(posedge wrapper_test_clock or posedge wr_rst) begin
        if (wr_rst) begin
            wr_reg.ir_shift <= WSCTE_IR_RESET;
            wr_reg.ring <= 1'b0;
            wr_reg.scan <= 1'b0;
            wr_reg.test <= 1'b0;
            wr_reg.bypass <= 1'b0;
            wr_reg.sout <= 1'b0;
            wr_reg.step_tgl <= 1'b0;
        end else begin
            wr_reg <= wr_next;
        end
    end

    assign serial_test_out = wr_reg.sout;
    // the internal chain follows the last boundary cell
    assign internal_chain_in = bc_sout;
    // The core shifts its cells on shift_en while this is high, also during
    // instruction loads, so reload the chain after a new instruction
    // scan mode keeps the boundary chain on the path and inward
    assign internal_chain_mode = wr_reg.scan;

    // Test level and step toggle into the core clock domain
    // Only single-bit levels cross here; the stimulus word waits for the toggle
    wscte_sync #(
        .W(2)
    ) u_sync_ctl (
        .clk(clock),
        .rst(rst),
        .ce(ce),
        .d({wr_reg.step_tgl, wr_reg.test}),
        .q(wr_to_core)
    );

    // Functional pins into the core clock domain
    wscte_sync #(
        .W(WSCTE_CORE_IN_W)
    ) u_sync_func (
        .clk(clock),
        .rst(rst),
        .ce(ce),
        .d(func_in),
        .q(func_in_sync)
    );

    // Stimulus is read only after its toggle passed two flops, so updates
    // must be at least four core clocks apart
    always_comb begin
        cr_next = cr_reg;
        if (ce) begin
            cr_next.test = wr_to_core[0];
            cr_next.tgl_seen = wr_to_core[1];
            cr_next.step = 1'b0;
            // stimulus held stable while its toggle crosses
            if (wr_to_core[1] != cr_reg.tgl_seen) begin
                cr_next.stim = bc_stim;
                // exactly one step per complete fill
                // step pulse allows free-running core clocks
                cr_next.step = wr_to_core[0];
            end
            // leaving test drops the held stimulus
            if (!wr_to_core[0]) begin
                cr_next.stim = WSCTE_CORE_IN_RESET;
            end
            // boundary values drive the core in test
            if (wr_to_core[0]) begin
                cr_next.cin = cr_next.stim;
            end else begin
                cr_next.cin = func_in_sync;
            end
            // functional outputs forced safe during test
            if (wr_to_core[0]) begin
                cr_next.fout = WSCTE_SAFE_OUT;
            end else begin
                cr_next.fout = core_out;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cr_reg.tgl_seen <= 1'b0;
            cr_reg.test <= 1'b0;
            cr_reg.step <= 1'b0;
            cr_reg.stim <= WSCTE_CORE_IN_RESET;
            cr_reg.cin <= WSCTE_CORE_IN_RESET;
            cr_reg.fout <= WSCTE_FOUT_RESET;
        end else begin
            cr_reg <= cr_next;
        end
    end

    assign core_in = cr_reg.cin;
    assign functional_output_terminal = cr_reg.fout;
    assign core_step = cr_reg.step;
    assign core_test_mode = cr_reg.test;

endmodule

// ---- tb/wscte_chk_sva.sv ----
// Checker for the wrapper core-test paths, watching the top-level ports.
// Assumes clock and wrapper_test_clock are unrelated and rst clears both domains.
module wscte_chk
    import wscte_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic wrapper_test_clock,
    input wire logic wrapper_reset_n,
    input wire logic update_en,
    input wire logic serial_test_out,
    input wire logic internal_chain_mode,
    input wire logic [WSCTE_CORE_IN_W-1:0] core_in,
    input wire logic [WSCTE_CORE_OUT_W-1:0] core_out,
    input wire logic [WSCTE_CORE_OUT_W-1:0] functional_output_terminal,
    input wire logic core_step,
    input wire logic core_test_mode
);
    timeunit 1ns;
    timeprecision 100ps;

    a_fout_safe: assert property (@(posedge clock) disable iff (rst)
        core_test_mode && $past(core_test_mode) |-> functional_output_terminal == WSCTE_SAFE_OUT)
        else $error("functional outputs not safe in test");
    a_step_once: assert property (@(posedge clock) disable iff (rst)
        core_step |=> !core_step [*3]) else $error("step pulse too long");
    a_step_test: assert property (@(posedge clock) disable iff (rst)
        core_step |-> core_test_mode) else $error("step outside test");
    a_core_in_held: assert property (@(posedge clock) disable iff (rst)
        core_test_mode && $past(core_test_mode) && $past(core_test_mode, 2) && !core_step
        |-> $stable(core_in)) else $error("stimulus moved without step");
    a_mode_holds: assert property (@(posedge wrapper_test_clock)
        disable iff (rst || !wrapper_reset_n)
        !update_en && !$past(update_en) |=> $stable(internal_chain_mode))
        else $error("path changed without update");
    a_wreset_clears: assert property (@(posedge wrapper_test_clock) disable iff (rst)
        !wrapper_reset_n |-> !internal_chain_mode && !serial_test_out)
        else $error("wrapper reset did not clear");
    a_test_drop: assert property (@(posedge clock) disable iff (rst)
        $fell(wrapper_reset_n) |-> ##[1:4] !core_test_mode) else $error("test mode kept");
    a_fout_normal: assert property (@(posedge clock) disable iff (rst)
        !core_test_mode && !$past(core_test_mode)
        |-> functional_output_terminal == $past(core_out)) else $error("outputs not functional");

    c_step: cover property (@(posedge clock) core_step);
    c_scan: cover property (@(posedge wrapper_test_clock) $rose(internal_chain_mode));
    c_leave: cover property (@(posedge clock) $fell(core_test_mode));
endmodule

bind wscte_top wscte_chk u_chk (.clock(clock), .rst(rst), .wrapper_test_clock(wrapper_test_clock),
    .wrapper_reset_n(wrapper_reset_n), .update_en(update_en), .serial_test_out(serial_test_out),
    .internal_chain_mode(internal_chain_mode), .core_in(core_in), .core_out(core_out),
    .functional_output_terminal(functional_output_terminal), .core_step(core_step),
    .core_test_mode(core_test_mode));

// ---- tb/wscte_core_model.sv ----
// Core model: a one-step response register and a two-cell internal scan chain.
// Assumes core_step comes on clock and the scan cells shift on wrapper_test_clock.
module wscte_core_model
    import wscte_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic wrapper_test_clock,
    input wire logic shift_en,
    input wire logic internal_chain_mode,
    input wire logic internal_chain_in,
    input wire logic core_step,
    input wire logic [WSCTE_CORE_IN_W-1:0] core_in,
    output logic [WSCTE_CORE_OUT_W-1:0] core_out,
    output logic internal_chain_tail
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [WSCTE_CORE_OUT_W-1:0] resp_reg;
    logic [1:0] scan_reg;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) resp_reg <= 4'h0;
        else if (core_step) resp_reg <= core_in + 4'h1;
    end
    always_ff @(posedge wrapper_test_clock or posedge rst) begin
        if (rst) scan_reg <= 2'h0;
        else if (internal_chain_mode && shift_en) scan_reg <= {scan_reg[0], internal_chain_in};
    end
    assign core_out = resp_reg;
    assign internal_chain_tail = scan_reg[1];
endmodule

// ---- tb/wscte_top_tb.sv ----
// Self-checking bench for the wrapper ring and scan core-test paths.
// Assumes the bench plays the test controller; the core model is the far side.
module wscte_top_tb;
    import wscte_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock, rst, wrapper_test_clock, wrapper_reset_n, select_instr, capture_en;
    logic shift_en, update_en, serial_test_in, serial_test_out, internal_chain_mode;
    logic internal_chain_in, internal_chain_tail, core_step, core_test_mode;
    logic [3:0] func_in, core_in, core_out, functional_output_terminal;
    int n_errors = 0;
    int checks_done = 0;
    int cyc = 0;
    int n_step = 0;

    initial begin
        clock = 0;
        forever #50 clock = ~clock;
    end
    initial begin
        wrapper_test_clock = 0;
        #7;
        forever #15 wrapper_test_clock = ~wrapper_test_clock;
    end

    wscte_top uut (.clock(clock), .rst(rst), .ce(1'b1), .wrapper_test_clock(wrapper_test_clock),
        .wrapper_reset_n(wrapper_reset_n), .select_instr(select_instr), .capture_en(capture_en),
        .shift_en(shift_en), .update_en(update_en), .serial_test_in(serial_test_in),
        .serial_test_out(serial_test_out), .internal_chain_mode(internal_chain_mode),
        .internal_chain_in(internal_chain_in), .internal_chain_tail(internal_chain_tail),
        .func_in(func_in), .core_in(core_in), .core_out(core_out),
        .functional_output_terminal(functional_output_terminal), .core_step(core_step),
        .core_test_mode(core_test_mode));
    wscte_core_model core (.clock(clock), .rst(rst), .wrapper_test_clock(wrapper_test_clock),
        .shift_en(shift_en), .internal_chain_mode(internal_chain_mode),
        .internal_chain_in(internal_chain_in), .core_step(core_step), .core_in(core_in),
        .core_out(core_out), .internal_chain_tail(internal_chain_tail));

    task close_out;
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    always @(posedge clock) begin
        cyc++;
        if (core_step === 1'b1) n_step++;
        if (cyc > 4000) begin
            n_errors++;
            close_out();
        end
    end

    task chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task wcyc(input logic s, input logic c, input logic sh, input logic u, input logic d);
        @(posedge wrapper_test_clock);
        #1;
        {select_instr, capture_en, shift_en, update_en, serial_test_in} = {s, c, sh, u, d};
    endtask

    task ir(input logic [2:0] op);
        for (int i = 0; i < 3; i++) wcyc(1, 0, 1, 0, op[i]);
        wcyc(1, 0, 0, 1, 0);
        wcyc(0, 0, 0, 0, 0);
        repeat (6) @(posedge clock);
        #1;
    endtask

    task dr(input logic [7:0] v, output logic [7:0] o);
        wcyc(0, 1, 0, 0, 0);
        for (int i = 0; i < 8; i++) begin
            wcyc(0, 0, 1, 0, v[7 - i]);
            if (i > 0) o = {o[6:0], serial_test_out};
        end
        wcyc(0, 0, 0, 1, 0);
        o = {o[6:0], serial_test_out};
        repeat (16) wcyc(0, 0, 0, 0, 0);
    endtask

    task measure(output int k);
        repeat (20) wcyc(0, 0, 1, 0, 0);
        wcyc(0, 0, 1, 0, 1);
        k = 0;
        do begin
            wcyc(0, 0, 1, 0, 0);
            k++;
        end while (serial_test_out !== 1'b1 && k < 40);
        wcyc(0, 0, 0, 0, 0);
    endtask

    task t_normal(input logic [3:0] v);
        func_in = v;
        repeat (6) @(posedge clock);
        #1;
        chk(core_in, v);
        chk(core_test_mode, 0);
        chk(functional_output_terminal, core_out);
    endtask

    task t_ring;
        logic [7:0] o;
        int k;
        ir(WSCTE_OP_RING);
        chk(core_test_mode, 1);
        chk(internal_chain_mode, 0);
        chk(functional_output_terminal, WSCTE_SAFE_OUT);
        dr(8'h05, o);
        func_in = 4'hF;
        chk(core_in, 4'h5);
        chk(n_step, 1);
        dr(8'hA3, o);
        chk(o, 8'h65);
        chk(core_in, 4'h3);
        chk(n_step, 2);
        measure(k);
        chk(k, 9);
    endtask

    task t_scan;
        int k;
        ir(WSCTE_OP_SCAN);
        chk(internal_chain_mode, 1);
        chk(functional_output_terminal, WSCTE_SAFE_OUT);
        measure(k);
        chk(k, 11);
    endtask

    task t_wreset;
        wcyc(0, 0, 0, 0, 0);
        wrapper_reset_n = 0;
        wcyc(0, 0, 0, 0, 0);
        chk(internal_chain_mode, 0);
        chk(serial_test_out, 0);
        repeat (6) @(posedge clock);
        #1;
        chk(core_test_mode, 0);
        chk(functional_output_terminal, 4'h4);
        chk(core_in, 4'hF);
        wrapper_reset_n = 1;
        rst = 1;
        repeat (2) @(posedge clock);
        #1;
        rst = 0;
        t_normal(4'h7);
    endtask

    task t_bypass;
        int k;
        ir(3'h7);
        chk(core_test_mode, 0);
        chk(internal_chain_mode, 0);
        measure(k);
        chk(k, 2);
    endtask

    initial begin
        rst = 1;
        wrapper_reset_n = 1;
        {select_instr, capture_en, shift_en, update_en, serial_test_in} = 5'h00;
        func_in = 4'h9;
        repeat (12) @(posedge clock);
        #1;
        rst = 0;
        t_normal(4'h9);
        t_ring();
        t_scan();
        t_wreset();
        t_bypass();
        close_out();
    end
endmodule
